// ---- sim/host_trim_requester.sv ----
// Host-side model that drives the self-trim trigger pin.
// Assumes one clock shared with the block; the pin rests at a chosen level.
`timescale 1ns/1ps
module host_trim_requester #(
  parameter int LOW_CYC  = 6,
  parameter int HIGH_CYC = 6
) (
  input  wire logic i_clk,
  input  wire logic i_go,
  input  wire logic i_rest_high,
  output logic      o_trigger
);
  int cnt = 0;

  always @(posedge i_clk) begin
    if (i_go && cnt == 0) begin
      cnt <= LOW_CYC + HIGH_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  assign o_trigger = (cnt == 0) ? i_rest_high : (cnt <= HIGH_CYC);
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the mode-pin control block.
// Assumes the host model drives the trigger pin; the bench drives all else.
`timescale 1ns/1ps
module testbench;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        extended_control_mode  = 1'b0;
  logic        slv  = 1'b0;
  logic        aln  = 1'b0;
  logic        rin  = 1'b0;
  logic        go   = 1'b0;
  logic        rest = 1'b0;
  logic [15:0] c0   = 16'h0;
  logic [15:0] ce   = 16'h0;
  logic [5:0]  pins = 6'h0;
  logic        trig, ra, rb, run, ioff, qoff, irdy, qrdy, des, tp, one;
  logic [1:0]  ph;
  int          n_errors    = 0;
  int          checks_done = 0;

  always #2.5 clk = ~clk;

  host_trim_requester u_host (.i_clk(clk), .i_go(go), .i_rest_high(rest), .o_trigger(trig));

  converter_mode_pin_control #(
    .WAIT_LONG_CYC(40),
    .WAIT_SHORT_CYC(20),
    .TRIM_RUN_CYC(30)
  ) u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_extended_control_mode(extended_control_mode),
    .i_cfg0_word(c0), .i_cfge_word(ce), .i_slave_mode(slv), .i_align_enable(aln),
    .i_sync_reference_in(rin), .i_dual_edge_pin(pins[5]), .i_self_trim_wait_select(pins[4]),
    .i_trim_trigger_pin(trig), .i_power_down_i_channel(pins[3]),
    .i_power_down_q_channel(pins[2]), .i_test_pattern_select(pins[1]),
    .i_output_one_to_one_select(pins[0]), .o_sync_reference_out_a(ra),
    .o_sync_reference_out_b(rb), .o_divided_phase(ph), .o_dual_edge_mode(des),
    .o_self_trim_running(run), .o_i_channel_off(ioff), .o_q_channel_off(qoff),
    .o_i_channel_ready(irdy), .o_q_channel_ready(qrdy), .o_test_pattern_on(tp),
    .o_output_one_to_one(one)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input logic hi);
    rest <= hi;
    rst  <= 1'b1;
    cyc(4);
    rst  <= 1'b0;
  endtask

  task automatic run_len(input int lim, output int s, output int l);
    s = 0;
    l = 0;
    while (run !== 1'b1 && s < lim) begin
      cyc(1);
      s++;
    end
    while (run === 1'b1 && l < 100) begin
      cyc(1);
      l++;
    end
  endtask

  task automatic t_power_on;
    int s, l;
    do_reset(1'b0);
    run_len(60, s, l);
    chk(16'(s >= 20 && s < 30), 16'h1);
    chk(l[15:0], 16'h1e);
    pins[4] <= 1'b1;
    do_reset(1'b0);
    run_len(60, s, l);
    chk(16'(s >= 40 && s < 50), 16'h1);
    pins[4] <= 1'b0;
  endtask

  task automatic t_hold_off;
    int s, l;
    do_reset(1'b1);
    run_len(80, s, l);
    chk(s[15:0], 16'h50);
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    run_len(30, s, l);
    chk(l[15:0], 16'h1e);
    rest <= 1'b0;
  endtask

  task automatic trim_bit(input logic e, input logic [15:0] exp);
    int s, l;
    extended_control_mode <= e;
    cyc(6);
    c0[15] <= 1'b1;
    run_len(12, s, l);
    c0[15] <= 1'b0;
    chk(l[15:0], exp);
  endtask

  task automatic t_on_demand;
    int s, l;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
    run_len(30, s, l);
    chk(l[15:0], 16'h1e);
    trim_bit(1'b1, 16'h1e);
    trim_bit(1'b0, 16'h0);
  endtask

  task automatic t_modes;
    logic       e;
    logic [5:0] p;
    logic [15:0] w;
    for (int k = 0; k < 4; k++) begin
      e = k[0];
      p = k[1] ? 6'h2b : 6'h14;
      w = k[1] ? 16'h0 : 16'h1c80;
      extended_control_mode  <= e;
      pins <= p;
      c0   <= w;
      cyc(6);
      chk({11'h0, des, tp, ioff, qoff, one}, {11'h0, e ? w[7] : p[5], e ? w[12] : p[1],
          p[3] | (e & w[11]), p[2] | (e & w[10]), p[0]});
    end
    pins <= 6'h0;
    cyc(4);
    chk({15'h0, irdy}, 16'h0);
    cyc(14);
    chk({14'h0, irdy, qrdy}, 16'h3);
  endtask

  task automatic ref_cnt(input logic [15:0] exp);
    int   n;
    logic pv;
    n  = 0;
    pv = ra;
    repeat (16) begin
      cyc(1);
      if (ra === 1'b1 && pv === 1'b0) n++;
      if (ra !== rb) n += 100;
      pv = ra;
    end
    chk(n[15:0], exp);
  endtask

  task automatic t_ref;
    logic [1:0] p1;
    ce <= 16'h0;
    cyc(3);
    ref_cnt(16'h0);
    ce <= 16'h2;
    cyc(3);
    ref_cnt(16'h4);
    slv <= 1'b1;
    aln <= 1'b1;
    rin <= 1'b1;
    cyc(10);
    p1 = ph;
    rin <= 1'b0;
    cyc(5);
    rin <= 1'b1;
    cyc(10);
    chk({14'h0, p1 ^ ph}, 16'h0);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    summarize();
  end

  initial begin
    t_power_on();
    t_hold_off();
    t_on_demand();
    t_modes();
    t_ref();
    summarize();
  end
endmodule

// ---- verilog/converter_mode_pin_control.sv ----
// Mode-pin and control-word combining logic with self-trim sequencing.
// Pins are asynchronous and synchronised here; control words come from the
// register logic on the same clock.
`timescale 1ns/1ps
module converter_mode_pin_control #(
  parameter int unsigned WAIT_LONG_CYC  = 8192,
  parameter int unsigned WAIT_SHORT_CYC = 4096,
  parameter int unsigned TRIM_RUN_CYC   = 8000
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_extended_control_mode,
  input  wire logic [15:0] i_cfg0_word,
  input  wire logic [15:0] i_cfge_word,
  input  wire logic        i_slave_mode,
  input  wire logic        i_align_enable,
  input  wire logic        i_sync_reference_in,
  input  wire logic        i_dual_edge_pin,
  input  wire logic        i_self_trim_wait_select,
  input  wire logic        i_trim_trigger_pin,
  input  wire logic        i_power_down_i_channel,
  input  wire logic        i_power_down_q_channel,
  input  wire logic        i_test_pattern_select,
  input  wire logic        i_output_one_to_one_select,
  output logic             o_sync_reference_out_a,
  output logic             o_sync_reference_out_b,
  output logic [1:0]       o_divided_phase,
  output logic             o_dual_edge_mode,
  output logic             o_self_trim_running,
  output logic             o_i_channel_off,
  output logic             o_q_channel_off,
  output logic             o_i_channel_ready,
  output logic             o_q_channel_ready,
  output logic             o_test_pattern_on,
  output logic             o_output_one_to_one
);
  localparam int unsigned CNT_W = mode_ctrl_pkg::CNT_W;

  typedef enum logic [3:0] {
    ST_INIT = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN  = 4'h4,
    ST_IDLE = 4'h8
  } trim_state_e;

  typedef struct packed {
    logic [7:0]       s1;
    logic [7:0]       s2;
    logic             ref_prev;
    logic [1:0]       div;
    logic             ref_out;
    trim_state_e      st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] low_cnt;
    logic [CNT_W-1:0] high_cnt;
    logic             armed;
    logic             inhibit;
    logic [CNT_W-1:0] pu_i;
    logic [CNT_W-1:0] pu_q;
    logic             dual_edge;
    logic             tp;
    logic             one_to_one;
    logic             off_i;
    logic             off_q;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;
  logic   trig;
  logic   trig_fire;
  logic   ref_free;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Synchronised pins: 0 ref,1 dual,2 wait,3 trig,4 pdi,5 pdq,6 tp,7 1:1.
  // pin ORed with the register request bit only in extended mode.
  assign trig = cur_ff.s2[3] |
                (i_extended_control_mode & i_cfg0_word[mode_ctrl_pkg::CFG0_TRIM_REQ]);
  // qualified low phase followed by qualified high phase.
  assign trig_fire = cur_ff.armed && trig &&
                     (cur_ff.high_cnt >= CNT_W'(mode_ctrl_pkg::TRIG_HIGH_CYC - 1));

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.s1 = {i_output_one_to_one_select, i_test_pattern_select,
                 i_power_down_q_channel, i_power_down_i_channel, i_trim_trigger_pin,
                 i_self_trim_wait_select, i_dual_edge_pin, i_sync_reference_in};
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.ref_prev = cur_ff.s2[0];
    // realign the divider on the reference rising edge.
    if (i_align_enable && i_slave_mode && cur_ff.s2[0] && !cur_ff.ref_prev) begin
      nxt_ff.div = 2'h0;
    end else begin
      nxt_ff.div = cur_ff.div + 2'h1;
    end
    // toggle twice per four clocks gives a quarter-rate square wave.
    // outputs held low while the enable bit is clear.
    if (!i_cfge_word[mode_ctrl_pkg::CFGE_REF_OUT_EN]) begin
      nxt_ff.ref_out = 1'b0;
    end else if (cur_ff.div[0]) begin
      nxt_ff.ref_out = ~cur_ff.ref_out;
    end
    nxt_ff.dual_edge = i_extended_control_mode ?
                       i_cfg0_word[mode_ctrl_pkg::CFG0_DUAL_EDGE] : cur_ff.s2[1];
    // pin selects the pattern outside extended mode.
    // control bit only in extended mode.
    nxt_ff.tp = i_extended_control_mode ?
                i_cfg0_word[mode_ctrl_pkg::CFG0_TEST_PAT] : cur_ff.s2[6];
    nxt_ff.one_to_one = cur_ff.s2[7];
    // pins power channels down in both modes.
    // OR with control bits in extended mode.
    nxt_ff.off_i = cur_ff.s2[4] |
                   (i_extended_control_mode & i_cfg0_word[mode_ctrl_pkg::CFG0_PD_I]);
    nxt_ff.off_q = cur_ff.s2[5] |
                   (i_extended_control_mode & i_cfg0_word[mode_ctrl_pkg::CFG0_PD_Q]);
    nxt_ff.pu_i = cur_ff.off_i ? '0 : sat_inc(cur_ff.pu_i);
    nxt_ff.pu_q = cur_ff.off_q ? '0 : sat_inc(cur_ff.pu_q);
    // Trigger phase qualification.
    if (trig) begin
      nxt_ff.low_cnt  = '0;
      nxt_ff.high_cnt = sat_inc(cur_ff.high_cnt);
    end else begin
      nxt_ff.high_cnt = '0;
      nxt_ff.low_cnt  = sat_inc(cur_ff.low_cnt);
      if (cur_ff.low_cnt >= CNT_W'(mode_ctrl_pkg::TRIG_LOW_CYC - 1)) begin
        nxt_ff.armed = 1'b1;
      end
    end
    unique case (cur_ff.st)
      ST_INIT: begin
        // trigger high at power-on withholds the automatic run.
        // The trigger is sampled only once the synchronisers hold real pin levels.
        nxt_ff.cnt = sat_inc(cur_ff.cnt);
        if (cur_ff.cnt >= CNT_W'(mode_ctrl_pkg::SYNC_STAGES)) begin
          nxt_ff.inhibit = trig;
          nxt_ff.cnt     = '0;
          nxt_ff.st      = ST_WAIT;
        end
      end
      ST_WAIT: begin
        nxt_ff.cnt = sat_inc(cur_ff.cnt);
        if (cur_ff.inhibit) begin
          if (trig_fire) begin
            nxt_ff.armed = 1'b0;
            nxt_ff.cnt   = '0;
            nxt_ff.st    = ST_RUN;
          end
        // pin selects the long or short pre-trim wait.
        end else if (cur_ff.cnt >= (cur_ff.s2[2] ? CNT_W'(WAIT_LONG_CYC - 1) :
                                                  CNT_W'(WAIT_SHORT_CYC - 1))) begin
          nxt_ff.cnt = '0;
          nxt_ff.st  = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_ff.cnt = sat_inc(cur_ff.cnt);
        if (cur_ff.cnt >= CNT_W'(TRIM_RUN_CYC - 1)) begin
          nxt_ff.armed = 1'b0;
          nxt_ff.st    = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (trig_fire) begin
          nxt_ff.armed = 1'b0;
          nxt_ff.cnt   = '0;
          nxt_ff.st    = ST_RUN;
        end
      end
      default: nxt_ff.st = ST_INIT;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_ff    <= '0;
      cur_ff.st <= ST_INIT;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign o_sync_reference_out_a = cur_ff.ref_out;
  assign o_sync_reference_out_b = cur_ff.ref_out;
  assign o_divided_phase        = cur_ff.div;
  assign o_dual_edge_mode       = cur_ff.dual_edge;
  // running exactly while in the run state.
  assign o_self_trim_running    = (cur_ff.st == ST_RUN);
  assign o_i_channel_off        = cur_ff.off_i;
  assign o_q_channel_off        = cur_ff.off_q;
  assign o_i_channel_ready      = !cur_ff.off_i &&
                                  (cur_ff.pu_i >= CNT_W'(mode_ctrl_pkg::PU_DELAY_CYC));
  assign o_q_channel_ready      = !cur_ff.off_q &&
                                  (cur_ff.pu_q >= CNT_W'(mode_ctrl_pkg::PU_DELAY_CYC));
  assign o_test_pattern_on      = cur_ff.tp;
  assign o_output_one_to_one    = cur_ff.one_to_one;

  // Realignment may legally jump the phase, so the rate check skips slave alignment.
  assign ref_free = i_cfge_word[mode_ctrl_pkg::CFGE_REF_OUT_EN] &&
                    !(i_align_enable && i_slave_mode);

  a_ref_out_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_cfge_word[mode_ctrl_pkg::CFGE_REF_OUT_EN] |=> !o_sync_reference_out_a)
    else $error("reference output active while disabled");
  a_ref_quarter: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (ref_free [*3] ##0 $rose(o_sync_reference_out_a)
     ##1 ref_free [*2]) |-> $fell(o_sync_reference_out_a))
    else $error("reference output not quarter rate");
  a_align_reset: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_align_enable && i_slave_mode && cur_ff.s2[0] && !cur_ff.ref_prev) |=>
    (o_divided_phase == 2'h0))
    else $error("divider not aligned to reference");
  a_dual_edge_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_extended_control_mode |=>
    (o_dual_edge_mode == $past(i_cfg0_word[mode_ctrl_pkg::CFG0_DUAL_EDGE])))
    else $error("sampling mode not from control bit");
  a_dual_edge_pin: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_extended_control_mode |=> (o_dual_edge_mode == $past(cur_ff.s2[1])))
    else $error("sampling mode not from pin");
  a_test_pat_sel: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_extended_control_mode |=>
    (o_test_pattern_on == $past(i_cfg0_word[mode_ctrl_pkg::CFG0_TEST_PAT])))
    else $error("test pattern not from control bit");
  a_pd_or_i: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_extended_control_mode && i_cfg0_word[mode_ctrl_pkg::CFG0_PD_I]) |=> o_i_channel_off)
    else $error("i channel not powered down by control bit");
  a_pd_pin_q: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    cur_ff.s2[5] |=> (o_q_channel_off ##1 !o_q_channel_ready))
    else $error("q channel not powered down by pin");
  a_run_length: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_self_trim_running) |-> o_self_trim_running [*8])
    else $error("self-trim run cut short");
  a_one_to_one: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> (o_output_one_to_one == $past(cur_ff.s2[7])))
    else $error("output mode not from pin");
  a_inhibit_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cur_ff.st == ST_WAIT && cur_ff.inhibit && !trig_fire) |=> !o_self_trim_running)
    else $error("power-on self-trim not withheld");
  a_trig_start: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cur_ff.st == ST_IDLE && trig_fire) |=> o_self_trim_running)
    else $error("qualified trigger did not start self-trim");

  c_trim_run: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(o_self_trim_running));
  c_ref_toggle: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_sync_reference_out_b));
  c_demand_trim: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    cur_ff.st == ST_IDLE && trig_fire);
  c_align: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    i_align_enable && i_slave_mode && cur_ff.s2[0] && !cur_ff.ref_prev);
endmodule

// ---- verilog/mode_ctrl_pkg.sv ----
// Constants for the converter mode-pin control block.
// Assumes a single sampling-derived system clock and plain control-word ports.
// Behaviour
// - In slave alignment mode, divided clocks realign to the incoming reference clock.
// - When enabled, two reference outputs toggle at one quarter of the clock rate.
// - Register Eh bit 1 enables the reference outputs; disabled after reset.
// - Outside extended mode the dual-edge pin selects interleaved or independent sampling.
// - In extended mode, sampling mode comes from register 0h bit 7.
// - Wait-select pin picks long or short wait before power-on self-trim.
// - Trigger low for minimum time then high for minimum time starts one self-trim.
// - Trigger high at power-on withholds power-on self-trim until cycled low-high.
// - In extended mode the trigger pin is ORed with register 0h bit 15.
// - Running output is high exactly while a self-trim sequence executes.
// - Each power-down pin powers down its channel; release after a finite delay.
// - In extended mode power-down pins are ORed with register 0h bits 11 and 10.
// - Outside extended mode the test-pattern pin selects fixed repeating pattern output.
// - In extended mode test pattern comes only from register 0h bit 12.
// - Output one-to-one pin selects non-demultiplexed or demultiplexed output in all modes.
package mode_ctrl_pkg;
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned CFG0_DUAL_EDGE  = 7;
  localparam int unsigned CFG0_PD_Q       = 10;
  localparam int unsigned CFG0_PD_I       = 11;
  localparam int unsigned CFG0_TEST_PAT   = 12;
  localparam int unsigned CFG0_TRIM_REQ   = 15;
  localparam int unsigned CFGE_REF_OUT_EN = 1;
  localparam int unsigned TRIG_LOW_NS     = 20;
  localparam int unsigned TRIG_HIGH_NS    = 20;
  localparam int unsigned TRIG_LOW_CYC    = (TRIG_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TRIG_HIGH_CYC   = (TRIG_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PU_DELAY_NS     = 50;
  localparam int unsigned PU_DELAY_CYC    = (PU_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W           = 16;
  localparam int unsigned SYNC_STAGES     = 2;
  localparam logic [1:0]  DIV_LAST        = 2'h3;
endpackage
